//--- rtl/adc_mode_pkg.sv
// shared constants and types for the converter mode-control block
package adc_mode_pkg;
    // ************************************************************
    // frame counts
    // ************************************************************
    localparam int unsigned FRAME_EDGES     = 16;  // full conversion
    localparam int unsigned LEAD_ZEROS      = 4;   // zeros before data
    localparam int unsigned GLITCH_EDGES    = 2;   // below: no mode change
    localparam int unsigned KEEP_EDGES      = 10;  // at or above: powered
    localparam int unsigned TRACK_EDGES     = 13;  // back to track after
    localparam int unsigned RESULT_BITS     = 12;
    localparam int unsigned CNT_W           = 5;
    // ************************************************************
    // timing
    // ************************************************************
    localparam int unsigned CLK_MHZ         = 250;
    localparam int unsigned POWERUP_NS      = 1000;
    // least time: round up
    localparam int unsigned POWERUP_CYC     =
        (POWERUP_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned PU_W            = 12;
    localparam logic        RESET_POWERED   = 1'b1;

    // status seen by the analog side and the outside
    typedef struct packed {
        logic powered;     // analog circuitry on
        logic ready;       // power-up time has elapsed
        logic hold;        // track-and-hold in hold
        logic converting;  // conversion in progress
    } mode_status_type;
endpackage : adc_mode_pkg

//--- rtl/result_latch.sv
// result register: holds the sampled conversion word for shifting out
`timescale 1ns/10ps
module result_latch #(
    parameter int unsigned WIDTH = 12
) (
    input  wire logic             i_clk,
    input  wire logic             i_reset,
    input  wire logic             i_load,
    input  wire logic [WIDTH-1:0] i_data,
    output logic      [WIDTH-1:0] o_data
);
    // a frame's word is caught once, at the select falling edge
    always_ff @(posedge i_clk)
    begin
        if (i_reset)
            o_data <= '0;
        else if (i_load)
            o_data <= i_data;
    end
endmodule : result_latch

//--- rtl/adc_power_mode_control.sv
// mode control of a serial SAR converter: power, hold, serial output
// Function
// R01 - host holds select low ten edges
// R02 - rise at edges ten to fifteen: abort
// R03 - sixteen clocks complete one conversion
// R04 - select may idle high or low
// R05 - host waits quiet interval after release
// R06 - rise at edges two to nine: powerdown
// R07 - powerdown: analog off, output released
// R08 - rise before second edge: no change
// R09 - wake starts at select fall
// R10 - wake rise before tenth: powered down
// R11 - power-up takes about one microsecond
// R12 - quiet interval also after dummy cycle
// R13 - hold while down, track on wake edge
// R14 - short dummy cycle is enough
// R15 - host dummy cycle after supply
// R16 - dummy cycle allowed right after supply
// R17 - at supply, track-and-hold already tracking
// R18 - lower clock above 320 kSPS
// R19 - select fall: hold, sample, drive out
// R20 - four zeros then twelve bits MSB first
// R21 - sixteenth falling edge releases output
// R22 - powered flag and edge counter
`timescale 1ns/10ps
module adc_power_mode_control
    import adc_mode_pkg::*;
#(
    parameter int unsigned POWERUP_CYCLES = POWERUP_CYC
) (
    input  wire logic                   i_clk,
    input  wire logic                   i_reset,
    input  wire logic                   i_frame_select_n,
    input  wire logic                   i_serial_clock_in,
    input  wire logic [RESULT_BITS-1:0] i_sample_code,
    output logic                        o_serial_out,
    output logic                        o_serial_out_oe_n,
    output adc_mode_pkg::mode_status_type o_status
);
    import adc_mode_pkg::*;

    // ************************************************************
    // state
    // ************************************************************
    typedef enum logic [1:0] {IDLE, FRAME, DONE} phase_type;

    typedef struct packed {
        phase_type        phase;
        logic             cs_prev;
        logic             sck_prev;
        logic [CNT_W-1:0] edges;
        logic             powered;
        logic             waking;
        logic [PU_W-1:0]  pu_cnt;
        logic             ready;
        logic             hold;
        logic             dout;
        logic             oe_n;
        logic             converting;
    } state_type;

    state_type s_q;
    state_type s_d;
    logic [RESULT_BITS-1:0] word;
    logic                   cs_fall;
    logic                   cs_rise;
    logic                   sck_fall;
    logic                   sck_edge;

    // bit shown on the wire after n+1 falling edges of the frame
    function automatic logic frame_bit(input logic [CNT_W-1:0] n,
                                       input logic [RESULT_BITS-1:0] w);
        logic [CNT_W-1:0] k;
        k = '0;
        // past the last data bit the line is released; keep it defined
        if (n < CNT_W'(LEAD_ZEROS - 1)
            || n > CNT_W'(RESULT_BITS + LEAD_ZEROS - 2))
            frame_bit = 1'b0;
        else
        begin
            k = CNT_W'(RESULT_BITS + LEAD_ZEROS - 2) - n;
            frame_bit = w[k[3:0]];
        end
    endfunction : frame_bit

    result_latch #(.WIDTH(RESULT_BITS)) u_word (
        .i_clk   (i_clk),
        .i_reset (i_reset),
        .i_load  (cs_fall),
        .i_data  (i_sample_code),
        .o_data  (word)
    );

    assign cs_fall  = s_q.cs_prev & ~i_frame_select_n;
    assign cs_rise  = ~s_q.cs_prev & i_frame_select_n;
    assign sck_fall = s_q.sck_prev & ~i_serial_clock_in;
    assign sck_edge = s_q.sck_prev ^ i_serial_clock_in;

    // ************************************************************
    // next state
    // ************************************************************
    always_comb
    begin
        s_d = s_q;
        s_d.cs_prev  = i_frame_select_n;
        s_d.sck_prev = i_serial_clock_in;
        // power-up timer runs only while analog is on and not ready
        if (s_q.powered && !s_q.ready)
        begin
            if (s_q.pu_cnt >= PU_W'(POWERUP_CYCLES - 1))
                s_d.ready = 1'b1; // R11
            else
                s_d.pu_cnt = s_q.pu_cnt + PU_W'(1);
        end
        unique case (s_q.phase)
            IDLE, DONE:
            begin
                if (cs_fall)
                begin
                    s_d.phase = FRAME;
                    s_d.edges = '0; // R22
                    s_d.hold  = 1'b1; // R19
                    s_d.oe_n  = 1'b0; // R19
                    s_d.dout  = 1'b0; // R20
                    if (!s_q.powered)
                    begin
                        s_d.waking  = 1'b1; // R09
                        s_d.powered = 1'b1;
                        s_d.pu_cnt  = '0;
                        s_d.ready   = 1'b0;
                    end
                end
            end
            FRAME:
            begin
                if (cs_rise)
                begin
                    s_d.phase = IDLE;
                    s_d.oe_n  = 1'b1; // R02 R07
                    s_d.hold  = 1'b0;
                    s_d.waking = 1'b0;
                    if (s_q.waking && s_q.edges < CNT_W'(KEEP_EDGES))
                    begin
                        s_d.powered = 1'b0; // R10
                        s_d.hold    = 1'b1; // R13
                        s_d.ready   = 1'b0;
                    end
                    else if (!s_q.waking
                             && s_q.edges >= CNT_W'(GLITCH_EDGES)
                             && s_q.edges < CNT_W'(KEEP_EDGES))
                    begin
                        s_d.powered = 1'b0; // R06 R07
                        s_d.hold    = 1'b1; // R13
                        s_d.ready   = 1'b0;
                    end
                    // below two edges nothing changes R08
                end
                else
                begin
                    // waking part returns to track on first clock edge
                    if (s_q.waking && sck_edge && s_q.edges == '0)
                        s_d.hold = 1'b0; // R13
                    if (sck_fall)
                    begin
                        s_d.edges = s_q.edges + CNT_W'(1); // R22
                        s_d.dout  = frame_bit(s_q.edges, word); // R20
                        if (s_q.edges + CNT_W'(1) == CNT_W'(KEEP_EDGES))
                            s_d.waking = 1'b0; // R09
                        if (s_q.edges + CNT_W'(1) == CNT_W'(FRAME_EDGES))
                        begin
                            s_d.phase = DONE; // R03
                            s_d.oe_n  = 1'b1; // R21
                        end
                    end
                    // acquisition starts after the thirteenth edge
                    if (!s_q.waking && sck_edge && i_serial_clock_in
                        && s_q.edges >= CNT_W'(TRACK_EDGES))
                        s_d.hold = 1'b0;
                end
            end
            default:
                s_d.phase = IDLE;
        endcase
        // registered copy of the phase so the status output is a flop
        s_d.converting = (s_d.phase == FRAME);
    end

    // ************************************************************
    // registers
    // ************************************************************
    // supply-up: track already on, powered as strapped R17
    always_ff @(posedge i_clk)
    begin
        if (i_reset)
        begin
            s_q         <= '0;
            s_q.phase   <= IDLE;
            s_q.cs_prev <= 1'b1;
            s_q.powered <= RESET_POWERED;
            s_q.oe_n    <= 1'b1;
        end
        else
            s_q <= s_d;
    end

    assign o_serial_out      = s_q.dout;
    assign o_serial_out_oe_n = s_q.oe_n;
    assign o_status = '{powered: s_q.powered, ready: s_q.ready,
                        hold: s_q.hold, converting: s_q.converting};

    // ************************************************************
    // checks
    // ************************************************************
    chk_release_rise: assert property (@(posedge i_clk) disable iff (i_reset)
        (s_q.phase == FRAME && cs_rise) |=> s_q.oe_n) // R07
        else $error("output not released after select rise");
    chk_sixteen_end: assert property (@(posedge i_clk) disable iff (i_reset)
        (s_q.phase == FRAME && !cs_rise && sck_fall
         && s_q.edges == CNT_W'(FRAME_EDGES - 1)) |=> s_q.oe_n) // R21
        else $error("output not released at sixteenth edge");
    chk_fall_drive: assert property (@(posedge i_clk) disable iff (i_reset)
        (s_q.phase != FRAME && cs_fall) |=> (!s_q.oe_n && s_q.hold)) // R19
        else $error("select fall did not drive and hold");
    chk_down_win: assert property (@(posedge i_clk) disable iff (i_reset)
        (s_q.phase == FRAME && cs_rise && !s_q.waking
         && s_q.edges >= CNT_W'(GLITCH_EDGES)
         && s_q.edges < CNT_W'(KEEP_EDGES)) |=> !s_q.powered) // R06
        else $error("no power-down in window");
    chk_glitch_keep: assert property (@(posedge i_clk) disable iff (i_reset)
        (s_q.phase == FRAME && cs_rise && !s_q.waking
         && s_q.edges < CNT_W'(GLITCH_EDGES)) |=> $stable(s_q.powered)) // R08
        else $error("glitch changed mode");
    chk_keep_pow: assert property (@(posedge i_clk) disable iff (i_reset)
        (s_q.phase == FRAME && cs_rise
         && s_q.edges >= CNT_W'(KEEP_EDGES)) |=> s_q.powered) // R02
        else $error("powered lost after tenth edge");
    chk_wake_abort: assert property (@(posedge i_clk) disable iff (i_reset)
        (s_q.phase == FRAME && cs_rise && s_q.waking) |=> !s_q.powered) // R10
        else $error("short wake did not return to power-down");
    chk_lead_zero: assert property (@(posedge i_clk) disable iff (i_reset)
        (s_q.phase == FRAME && sck_fall && !cs_rise
         && s_q.edges < CNT_W'(LEAD_ZEROS - 1)) |=> !s_q.dout) // R20
        else $error("leading zero missing");
    chk_down_hold: assert property (@(posedge i_clk) disable iff (i_reset)
        (!s_q.powered && s_q.phase == IDLE) |-> s_q.hold) // R13
        else $error("not in hold while powered down");
endmodule : adc_power_mode_control

//--- test/host_serial_model.sv
// host serial port model: frames select and serial clock, reads data
`timescale 1ns/10ps
module host_serial_model (
    input  wire logic i_clk,
    input  wire logic i_serial_out,
    input  wire logic i_serial_out_oe_n,
    input  wire logic i_hold,
    output logic      o_frame_select_n,
    output logic      o_serial_clock_in
);
    // select idles high, clock stands still low between frames
    initial
    begin
        o_frame_select_n  = 1'b1;
        o_serial_clock_in = 1'b0;
    end

    // one frame of a given number of falling edges, MSB first capture
    task automatic frame(input int falls, output logic [15:0] word,
                         output logic [1:0] seen);
        logic bit_in;
        word = 16'h0000;
        seen = 2'b11;
        @(posedge i_clk);
        o_frame_select_n <= 1'b0;
        repeat (3) @(posedge i_clk);
        for (int k = 0; k < falls; k++)
        begin
            o_serial_clock_in <= 1'b1;
            repeat (2) @(posedge i_clk);
            #1;
            if (k == 0)
                seen = {i_hold, i_serial_out_oe_n};
            // a released line reads inverted, so a late read shows up
            bit_in = i_serial_out_oe_n ? ~i_serial_out : i_serial_out;
            word = {word[14:0], bit_in};
            @(posedge i_clk);
            o_serial_clock_in <= 1'b0;
            repeat (2) @(posedge i_clk);
        end
        o_frame_select_n <= 1'b1;
        // quiet interval before any later frame
        repeat (8) @(posedge i_clk);
        #1;
    endtask : frame
endmodule : host_serial_model

//--- test/tb_adc_power_mode_control.sv
// self-checking bench of the converter mode-control block
`timescale 1ns/10ps
module tb_adc_power_mode_control;
    import adc_mode_pkg::*;
    // ************************************************************
    // signals and instances
    // ************************************************************
    localparam int unsigned PU = 4; // short power-up keeps runs brief
    logic                   i_clk;
    logic                   i_reset;
    logic [RESULT_BITS-1:0] code;
    logic                   fs_n;
    logic                   sck;
    logic                   sdo;
    logic                   oe_n;
    mode_status_type        st;
    logic [15:0]            word;
    logic [1:0]             seen;
    int                     error_cnt;
    int                     total_checks;

    initial
    begin
        i_clk = 1'b0;
        forever #2 i_clk = ~i_clk;
    end

    adc_power_mode_control #(.POWERUP_CYCLES(PU)) dut (
        .i_clk             (i_clk),
        .i_reset           (i_reset),
        .i_frame_select_n  (fs_n),
        .i_serial_clock_in (sck),
        .i_sample_code     (code),
        .o_serial_out      (sdo),
        .o_serial_out_oe_n (oe_n),
        .o_status          (st)
    );

    host_serial_model host (
        .i_clk             (i_clk),
        .i_serial_out      (sdo),
        .i_serial_out_oe_n (oe_n),
        .i_hold            (st.hold),
        .o_frame_select_n  (fs_n),
        .o_serial_clock_in (sck)
    );
    // ************************************************************
    // shared tasks
    // ************************************************************
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, got, exp);
        end
    endtask : check

    task automatic summarize();
        $display("checks=%0d errors=%0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : summarize

    // powered, ready, hold, converting as one nibble
    function automatic logic [15:0] stv();
        return {12'h000, st};
    endfunction : stv
    // ************************************************************
    // scenarios
    // ************************************************************
    task automatic test_reset();
        int n;
        check(stv(), 16'h0008);
        check({15'h0000, oe_n}, 16'h0001);
        n = 0;
        // bounded wait for the power-up timer
        while (st.ready !== 1'b1 && n < 300)
        begin
            @(posedge i_clk);
            n++;
        end
        #1;
        if (n >= 300)
        begin
            error_cnt++;
            summarize();
        end
        check(stv(), 16'h000C);
    endtask : test_reset

    task automatic test_full(input logic [11:0] c);
        @(posedge i_clk);
        code <= c;
        host.frame(16, word, seen);
        check(word, {4'h0, c});
        check({14'h0000, seen}, 16'h0002);
        check({15'h0000, oe_n}, 16'h0001);
        check(stv(), 16'h000C);
    endtask : test_full

    // rise after a table of edge counts, from powered state
    task automatic test_window();
        int          falls [5] = '{1, 2, 9, 10, 15};
        logic [15:0] exp   [5] = '{16'hC, 16'h2, 16'h2, 16'hC, 16'hC};
        for (int i = 0; i < 5; i++)
        begin
            @(posedge i_clk);
            code <= 12'h5A3;
            host.frame(falls[i], word, seen);
            check(stv(), exp[i]);
            check({15'h0000, oe_n}, 16'h0001);
            if (exp[i] == 16'h2)
                host.frame(10, word, seen);
        end
    endtask : test_window

    task automatic test_wake();
        host.frame(5, word, seen);
        check(stv(), 16'h0002);
        host.frame(8, word, seen);
        check(stv(), 16'h0002);
        host.frame(10, word, seen);
        check({15'h0000, seen[1]}, 16'h0000);
        check(stv(), 16'h000C);
        test_full(12'h3F1);
    endtask : test_wake
    // ************************************************************
    // main sequence
    // ************************************************************
    initial
    begin
        error_cnt    = 0;
        total_checks = 0;
        i_reset      = 1'b1;
        code         = 12'h000;
        repeat (6) @(posedge i_clk);
        i_reset <= 1'b0;
        @(posedge i_clk);
        #1;
        test_reset();
        test_full(12'hA5C);
        test_full(12'hFFF);
        test_window();
        test_wake();
        summarize();
    end
endmodule : tb_adc_power_mode_control
